// ### logic/bcbc_comparator.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
// Contract
// R1: Break address is 32 bits, high register bits 31-16, low 15-0.
// R2: Mask bit 1 drops that address bit from the compare, 0 keeps it.
// R3: Source field: 01 core cycles, 10 transfer-controller cycles, 11 both.
// R4: Type field: 01 instruction fetch, 10 data access, 11 both.
// R5: Direction field: 01 read, 10 write, 11 both.
// R6: Any of source, type or direction at 00 means no break ever.
// R7: Size field 00 ignores size, else byte 01, word 10, long 11.
// R8: Every instruction fetch counts as a word access.
// R9: Software clears size low bit when breaking on instruction fetch.
// R10: Compared size is the master's requested size, not bus width.
// R11: Disable bit 1 suppresses the interrupt request, 0 allows it.
// R12: Width field: trigger low 1, 4, 8 or 16 clock periods.
// R13: Each satisfied condition shows on the low-active trigger pin.
// R14: Reserved upper bits read zero; software writes them zero.
// R15: Interrupt request issued whenever all conditions match a cycle.
// R16: Fetch break is requested before the matching instruction runs.
// R17: Comparator can be put into module standby.
// R18: Mask and cycle and control fields are zero after reset.
// R19: Trigger pulse starts together with the interrupt request.
// R20: Interrupt request carries priority level 15.
// R21: Match is AND of masked address and enabled conditions, per cycle.
module bcbc_comparator
  import bcbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic module_standby,
  input wire logic bus_cycle_valid,
  input wire logic [31:0] bus_addr,
  input wire logic bus_from_dtc,
  input wire logic bus_fetch,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  output logic break_irq_req,
  output logic [3:0] break_irq_level,
  output logic match_trigger_n
);

  logic [15:0] addr_high_r;
  logic [15:0] addr_low_r;
  logic [15:0] mask_high_r;
  logic [15:0] mask_low_r;
  logic [BCBC_CS_WIDTH-1:0] cycle_sel_r;
  logic [BCBC_CT_WIDTH-1:0] control_r;
  logic match_seen_r;
  bcbc_trig_e trig_state_r;
  logic [4:0] trig_count_r;

  logic [31:0] break_addr;
  logic [31:0] break_mask;
  logic [31:0] addr_diff;
  logic [1:0] src_field;
  logic [1:0] type_field;
  logic [1:0] dir_field;
  logic [1:0] size_field;
  logic [1:0] pw_field;
  logic addr_hit;
  logic src_hit;
  logic type_hit;
  logic dir_hit;
  logic size_hit;
  logic [1:0] eff_size;
  logic cond_match;
  logic cycle_ok;
  logic [4:0] pw_cycles;

  logic access;
  logic wr_en;
  logic rd_en;
  logic addr_mapped;
  logic [31:0] rd_word;
  logic [15:0] wr_half;
  logic seen_clear;

  // Register fields seen by the comparator
  // R1: address halves
  assign break_addr = {addr_high_r, addr_low_r};
  assign break_mask = {mask_high_r, mask_low_r};
  assign src_field = cycle_sel_r[BCBC_CS_SRC_LSB +: 2];
  assign type_field = cycle_sel_r[BCBC_CS_TYPE_LSB +: 2];
  assign dir_field = cycle_sel_r[BCBC_CS_DIR_LSB +: 2];
  assign size_field = cycle_sel_r[BCBC_CS_SIZE_LSB +: 2];
  assign pw_field = control_r[BCBC_CT_PW_LSB +: 2];

  // R2: masked compare, one term per address bit
  for (genvar gi = 0; gi < 32; gi++) begin : g_addr_bit
    // A mask bit of 1 forces the term to agree
    assign addr_diff[gi] = (bus_addr[gi] ^ break_addr[gi]) &&
                           !break_mask[gi];
  end
  assign addr_hit = (addr_diff == 32'h0000_0000);

  // R3: source select; code 00 selects nothing
  always_comb begin
    case (src_field)
      2'b01: src_hit = !bus_from_dtc;
      2'b10: src_hit = bus_from_dtc;
      2'b11: src_hit = 1'b1;
      // R6: code 00 closes this group
      default: src_hit = 1'b0;
    endcase
  end

  // R4: fetch or data select
  always_comb begin
    case (type_field)
      2'b01: type_hit = bus_fetch;
      2'b10: type_hit = !bus_fetch;
      2'b11: type_hit = 1'b1;
      // R6: code 00 closes this group
      default: type_hit = 1'b0;
    endcase
  end

  // R5: read or write select
  always_comb begin
    case (dir_field)
      2'b01: dir_hit = !bus_write;
      2'b10: dir_hit = bus_write;
      2'b11: dir_hit = 1'b1;
      // R6: code 00 closes this group
      default: dir_hit = 1'b0;
    endcase
  end

  // R8: fetches count as word size, even paired fetches
  // R10: size is the requested one, never the port width
  always_comb begin
    if (bus_fetch) begin
      eff_size = BCBC_SZ_WORD;
    end else begin
      eff_size = bus_size;
    end
  end

  // R7: size condition
  // R9: a set size low bit on fetch can never match word
  always_comb begin
    case (size_field)
      BCBC_SZ_BYTE: size_hit = (eff_size == BCBC_SZ_BYTE);
      BCBC_SZ_WORD: size_hit = (eff_size == BCBC_SZ_WORD);
      BCBC_SZ_LONG: size_hit = (eff_size == BCBC_SZ_LONG);
      // Code 00 leaves operand size out of the match
      default: size_hit = 1'b1;
    endcase
  end

  // R21: cycle attributes first, then address and standby gate
  assign cycle_ok = src_hit && type_hit && dir_hit && size_hit;

  // R21: one decision per bus cycle
  // R6: a 00 group leaves its hit term low
  // R17: standby freezes the comparator
  assign cond_match = bus_cycle_valid && !module_standby && addr_hit &&
                      cycle_ok;

  // R12: pulse length per width code
  always_comb begin
    case (pw_field)
      2'b00: pw_cycles = BCBC_PW_CYC_DIV1;
      2'b01: pw_cycles = BCBC_PW_CYC_DIV4;
      2'b10: pw_cycles = BCBC_PW_CYC_DIV8;
      2'b11: pw_cycles = BCBC_PW_CYC_DIV16;
      default: pw_cycles = BCBC_PW_CYC_DIV1;
    endcase
  end

  // APB decode; one wait state so read data comes from a flop
  assign access = psel && penable && !pready;
  assign wr_en = access && pwrite && addr_mapped;
  assign rd_en = access && !pwrite;

  always_comb begin
    addr_mapped = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      BCBC_OFS_ADDR_HIGH: rd_word = {16'h0000, addr_high_r};
      BCBC_OFS_ADDR_LOW: rd_word = {16'h0000, addr_low_r};
      BCBC_OFS_MASK_HIGH: rd_word = {16'h0000, mask_high_r};
      BCBC_OFS_MASK_LOW: rd_word = {16'h0000, mask_low_r};
      // R14: reserved bits read zero
      BCBC_OFS_CYCLE_SEL: rd_word = {24'h00_0000, cycle_sel_r};
      BCBC_OFS_CONTROL: rd_word = {29'h0000_0000, control_r};
      BCBC_OFS_STATUS: begin
        rd_word[BCBC_ST_TRIG_BIT] = (trig_state_r == BCBC_TRIG_LOW);
        rd_word[BCBC_ST_SEEN_BIT] = match_seen_r;
      end
      default: addr_mapped = 1'b0;
    endcase
  end

  // Byte strobes merge into the 16-bit halves
  function automatic logic [15:0] merge_half(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  assign wr_half = pwdata[15:0];
  assign seen_clear = wr_en && (paddr == BCBC_OFS_STATUS) && pstrb[0] &&
                      pwdata[BCBC_ST_SEEN_BIT];

  // Bus handshake; the wait state lets read data leave a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  // Unmapped offsets are refused with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access && !addr_mapped;
    end
  end

  // Read data; cleared on other accesses so a refused read returns zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && addr_mapped) begin
      prdata <= rd_word;
    end else if (access) begin
      prdata <= 32'h0000_0000;
    end
  end

  // Break address cleared at reset so the first compare is known
  // R1: high half written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_high_r <= BCBC_RST_HALF;
    end else if (wr_en && paddr == BCBC_OFS_ADDR_HIGH) begin
      addr_high_r <= merge_half(addr_high_r, pwdata, pstrb);
    end
  end

  // R1: low half written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_r <= BCBC_RST_HALF;
    end else if (wr_en && paddr == BCBC_OFS_ADDR_LOW) begin
      addr_low_r <= merge_half(addr_low_r, pwdata, pstrb);
    end
  end

  // R18: mask high half cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_high_r <= BCBC_RST_HALF;
    end else if (wr_en && paddr == BCBC_OFS_MASK_HIGH) begin
      mask_high_r <= merge_half(mask_high_r, pwdata, pstrb);
    end
  end

  // R18: mask low half cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_low_r <= BCBC_RST_HALF;
    end else if (wr_en && paddr == BCBC_OFS_MASK_LOW) begin
      mask_low_r <= merge_half(mask_low_r, pwdata, pstrb);
    end
  end

  // R18: condition fields cleared at reset
  // R14: upper bits are not stored, so writes there are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_sel_r <= BCBC_RST_CYCLE_SEL;
    end else if (wr_en && pstrb[0] && paddr == BCBC_OFS_CYCLE_SEL) begin
      cycle_sel_r <= wr_half[BCBC_CS_WIDTH-1:0];
    end
  end

  // R18: control fields cleared at reset
  // R11: disable bit stored with the width code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_r <= BCBC_RST_CONTROL;
    end else if (wr_en && pstrb[0] && paddr == BCBC_OFS_CONTROL) begin
      control_r <= wr_half[BCBC_CT_WIDTH-1:0];
    end
  end

  // Sticky match flag; a new match beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_seen_r <= 1'b0;
    end else if (cond_match) begin
      match_seen_r <= 1'b1;
    end else if (seen_clear) begin
      match_seen_r <= 1'b0;
    end
  end

  // R15: request on every full match
  // R11: disable bit gates only the request
  // R16: raised the cycle after the fetch, ahead of its execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_irq_req <= 1'b0;
    end else begin
      break_irq_req <= cond_match && !control_r[BCBC_CT_DIS_BIT];
    end
  end

  // R20: fixed priority level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_irq_level <= 4'h0;
    end else begin
      break_irq_level <= BCBC_IRQ_LEVEL;
    end
  end

  // Trigger pulse; a match during a pulse restarts its length
  // R13: low while the pulse runs
  // R19: starts on the same edge as the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_state_r <= BCBC_TRIG_IDLE;
      trig_count_r <= 5'h00;
      match_trigger_n <= 1'b1;
    end else if (cond_match) begin
      trig_state_r <= BCBC_TRIG_LOW;
      trig_count_r <= pw_cycles - 5'h01;
      match_trigger_n <= 1'b0;
    end else begin
      case (trig_state_r)
        BCBC_TRIG_IDLE: begin
          match_trigger_n <= 1'b1;
        end
        BCBC_TRIG_LOW: begin
          // R12: hold low for the selected count
          // R17: standby ends a running pulse
          if (trig_count_r == 5'h00 || module_standby) begin
            trig_state_r <= BCBC_TRIG_IDLE;
            match_trigger_n <= 1'b1;
          end else begin
            trig_count_r <= trig_count_r - 5'h01;
          end
        end
        default: begin
          trig_state_r <= BCBC_TRIG_IDLE;
          match_trigger_n <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ### include/bcbc_pkg.sv
package bcbc_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] BCBC_OFS_ADDR_HIGH = 8'h00;
  localparam logic [7:0] BCBC_OFS_ADDR_LOW = 8'h04;
  localparam logic [7:0] BCBC_OFS_MASK_HIGH = 8'h08;
  localparam logic [7:0] BCBC_OFS_MASK_LOW = 8'h0C;
  localparam logic [7:0] BCBC_OFS_CYCLE_SEL = 8'h10;
  localparam logic [7:0] BCBC_OFS_CONTROL = 8'h14;
  localparam logic [7:0] BCBC_OFS_STATUS = 8'h18;

  // Field positions in break_cycle_select
  localparam int BCBC_CS_SRC_LSB = 6;
  localparam int BCBC_CS_TYPE_LSB = 4;
  localparam int BCBC_CS_DIR_LSB = 2;
  localparam int BCBC_CS_SIZE_LSB = 0;
  localparam int BCBC_CS_WIDTH = 8;

  // Field positions in break_control
  localparam int BCBC_CT_PW_LSB = 1;
  localparam int BCBC_CT_DIS_BIT = 0;
  localparam int BCBC_CT_WIDTH = 3;

  // Field positions in the status word
  localparam int BCBC_ST_TRIG_BIT = 0;
  localparam int BCBC_ST_SEEN_BIT = 1;

  // Values after reset
  localparam logic [15:0] BCBC_RST_HALF = 16'h0000;
  localparam logic [7:0] BCBC_RST_CYCLE_SEL = 8'h00;
  localparam logic [2:0] BCBC_RST_CONTROL = 3'h0;

  // Operand size codes as carried on the bus and in the size field
  localparam logic [1:0] BCBC_SZ_ANY = 2'h0;
  localparam logic [1:0] BCBC_SZ_BYTE = 2'h1;
  localparam logic [1:0] BCBC_SZ_WORD = 2'h2;
  localparam logic [1:0] BCBC_SZ_LONG = 2'h3;

  // Trigger low time in clock cycles per pulse-width code
  localparam logic [4:0] BCBC_PW_CYC_DIV1 = 5'h01;
  localparam logic [4:0] BCBC_PW_CYC_DIV4 = 5'h04;
  localparam logic [4:0] BCBC_PW_CYC_DIV8 = 5'h08;
  localparam logic [4:0] BCBC_PW_CYC_DIV16 = 5'h10;

  // Interrupt priority level presented with the request
  localparam logic [3:0] BCBC_IRQ_LEVEL = 4'hF;

  typedef enum logic [1:0] {
    BCBC_TRIG_IDLE = 2'b01,
    BCBC_TRIG_LOW = 2'b10
  } bcbc_trig_e;

endpackage

// ### testbench/bcbc_comparator_assertions.sv
`timescale 1ns/1ns
module bcbc_comparator_chk
  import bcbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic module_standby,
  input wire logic bus_cycle_valid,
  input wire logic break_irq_req,
  input wire logic [3:0] break_irq_level,
  input wire logic match_trigger_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_irq_level:
    assert property ($past(presetn) |-> break_irq_level == 4'hF)
    else $error("irq level not fifteen");
  chk_irq_with_trig:
    assert property (break_irq_req |-> !match_trigger_n)
    else $error("irq without trigger low");
  chk_irq_cause:
    assert property (break_irq_req |->
      $past(bus_cycle_valid) && !$past(module_standby))
    else $error("irq without a bus cycle");
  chk_trig_cause:
    assert property ($fell(match_trigger_n) |-> $past(bus_cycle_valid))
    else $error("trigger fell without a bus cycle");
  chk_standby_idle:
    assert property (module_standby ##1 module_standby |->
      match_trigger_n && !break_irq_req)
    else $error("activity in standby");
  chk_ready_pulse:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_access_ans:
    assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  chk_err_zero:
    assert property (pslverr && !pwrite |-> pready && prdata == 0)
    else $error("refused read not zero");
  chk_ctrl_resv:
    assert property (pready && !pwrite && paddr == BCBC_OFS_CONTROL |->
      prdata[31:3] == 0)
    else $error("control reserved bits set");
endmodule
bind bcbc_comparator bcbc_comparator_chk i_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .module_standby,
  .bus_cycle_valid, .break_irq_req, .break_irq_level, .match_trigger_n);

// ### testbench/bcbc_bus_master_model.sv
`timescale 1ns/1ns
module bcbc_bus_master_model (
  input wire logic pclk,
  output logic bus_cycle_valid = 1'b0,
  output logic [31:0] bus_addr = 32'h0000_0000,
  output logic bus_from_dtc = 1'b0,
  output logic bus_fetch = 1'b0,
  output logic bus_write = 1'b0,
  output logic [1:0] bus_size = 2'h1
);
  task automatic issue(logic [31:0] a, logic d, f, w, logic [1:0] s);
    @(posedge pclk);
    bus_cycle_valid <= 1'b1;
    bus_addr <= a;
    bus_from_dtc <= d;
    bus_fetch <= f;
    bus_write <= w;
    bus_size <= s;
    @(posedge pclk);
    // Stale address, source, type and direction inverted so a late sample cannot match
    bus_cycle_valid <= 1'b0;
    bus_addr <= ~a;
    bus_from_dtc <= ~d;
    bus_fetch <= ~f;
    bus_write <= ~w;
  endtask
endmodule

// ### testbench/bcbc_comparator_tb.sv
`timescale 1ns/1ns
module bcbc_comparator_tb
  import bcbc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic module_standby = 1'b0;
  logic [31:0] prdata, bus_addr;
  logic pready, pslverr, bus_cycle_valid, bus_from_dtc, bus_fetch, bus_write;
  logic [1:0] bus_size;
  logic break_irq_req, match_trigger_n;
  logic [3:0] break_irq_level;
  int err_count = 0;
  int cmp_count = 0;
  integer seed = 32'hf068_8aca;
  always #20 pclk = ~pclk;
  bcbc_comparator i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .module_standby,
    .bus_cycle_valid, .bus_addr, .bus_from_dtc, .bus_fetch, .bus_write,
    .bus_size, .break_irq_req, .break_irq_level, .match_trigger_n);
  bcbc_bus_master_model i_bm (.pclk, .bus_cycle_valid, .bus_addr,
    .bus_from_dtc, .bus_fetch, .bus_write, .bus_size);
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask
  task automatic conclude();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(bit wr, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    if (n >= 16) begin
      chk("apb wait", 0, 1);
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, q, x);
  endtask
  function automatic bit model(logic [7:0] cs, logic [31:0] ba, bm, a,
                               logic d, f, w, logic [1:0] s);
    logic [1:0] es;
    es = f ? 2'h2 : s;
    return (((a ^ ba) & ~bm) == 0) && cs[6 + d] && cs[4 + !f] &&
      cs[2 + w] && (cs[1:0] == 0 || cs[1:0] == es);
  endfunction
  task automatic hit(logic [31:0] a, logic d, f, w, logic [1:0] s,
                     bit ex, bit dis, int wd);
    int n;
    n = 0;
    i_bm.issue(a, d, f, w, s);
    #1;
    chk("irq", break_irq_req, ex & !dis);
    chk("trigger", match_trigger_n, !ex);
    while (match_trigger_n === 1'b0 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 40) begin
      chk("trigger wait", 0, 1);
      conclude();
    end
    if (ex) chk("width", n, wd);
  endtask
  initial begin
    logic [31:0] ba, bm, a, r, q;
    logic [7:0] cs;
    logic [2:0] ct;
    logic d, f, w, e;
    logic [1:0] s;
    bit m, seen;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd("reset", 8'(4 * i), 0);
    apb(1'b0, 8'h1C, 32'h0000_0000, q, e);
    chk("unmapped err", e, 1);
    chk("unmapped data", q, 0);
    chk("irq level", break_irq_level, 15);
    $display("Test reset done");
    wr(BCBC_OFS_MASK_HIGH, 32'h0000_FFFF);
    wr(BCBC_OFS_MASK_LOW, 32'h0000_FFFF);
    wr(BCBC_OFS_CYCLE_SEL, 32'h0000_00FC);
    wr(BCBC_OFS_CONTROL, 32'h0000_0000);
    module_standby <= 1'b1;
    hit(32'h1234_5678, 0, 0, 0, 2'h1, 0, 0, 1);
    @(posedge pclk);
    module_standby <= 1'b0;
    hit(32'h1234_5678, 1, 1, 1, 2'h3, 1, 0, 1);
    rd("seen set", BCBC_OFS_STATUS, 32'h0000_0002);
    wr(BCBC_OFS_STATUS, 32'h0000_0002);
    rd("seen clear", BCBC_OFS_STATUS, 32'h0000_0000);
    $display("Test standby done");
    seen = 1'b0;
    for (int k = 0; k < 120; k++) begin
      r = $random(seed);
      ba = $random(seed);
      bm = $random(seed) & $random(seed);
      cs = (r[7:0] | r[31:24]) & (r[23] ? 8'hFC : 8'hFF);
      ct = r[10:8];
      d = r[11];
      f = r[12];
      w = r[13];
      s = 2'(1 + r[15:14] % 3);
      // fetch breaks keep size low bit clear
      if (f) cs[0] = 1'b0;
      a = ba ^ ($random(seed) & bm);
      if (r[17:16] == 0) a[r[22:18]] = ~a[r[22:18]];
      wr(BCBC_OFS_ADDR_HIGH, {16'h0000, ba[31:16]});
      wr(BCBC_OFS_ADDR_LOW, {16'h0000, ba[15:0]});
      wr(BCBC_OFS_MASK_HIGH, {16'h0000, bm[31:16]});
      wr(BCBC_OFS_MASK_LOW, {16'h0000, bm[15:0]});
      wr(BCBC_OFS_CYCLE_SEL, {24'h00_0000, cs});
      wr(BCBC_OFS_CONTROL, {29'h0000_0000, ct});
      rd("cycle sel", BCBC_OFS_CYCLE_SEL, {24'h0, cs});
      rd("control", BCBC_OFS_CONTROL, {29'h0, ct});
      rd("addr high", BCBC_OFS_ADDR_HIGH, {16'h0, ba[31:16]});
      m = model(cs, ba, bm, a, d, f, w, s);
      seen = seen | m;
      hit(a, d, f, w, s, m, ct[0],
          ct[2:1] == 0 ? 1 : 2 << ct[2:1]);
    end
    rd("seen any", BCBC_OFS_STATUS, {30'h0000_0000, seen, 1'b0});
    $display("Test random match done");
    conclude();
  end
endmodule
